// >>> core/mdas_pkg.sv
// Constants and carrier types for the external data move access unit.
package mdas_pkg;

    // Special function register addresses.
    localparam logic [7:0] DP0_LOW_ADDR   = 8'h82;
    localparam logic [7:0] DP0_HIGH_ADDR  = 8'h83;
    localparam logic [7:0] DP1_LOW_ADDR   = 8'h84;
    localparam logic [7:0] DP1_HIGH_ADDR  = 8'h85;
    localparam logic [7:0] PTR_SEL_ADDR   = 8'h86;
    localparam logic [7:0] CLK_CTRL_ADDR  = 8'h8E;
    localparam logic [7:0] PWR_MGMT_ADDR  = 8'hC4;

    // Field positions.
    localparam int DME_LO_BIT      = 0;
    localparam int DME_HI_BIT      = 1;
    localparam int STRETCH_LSB     = 0;
    localparam int STRETCH_MSB     = 2;
    localparam int PTR_SEL_BIT     = 0;
    localparam int LOCK_BITS_W     = 3;

    // Reset values.
    localparam logic [7:0] DP_RESET       = 8'h00;
    localparam logic [7:0] PTR_SEL_RESET  = 8'h00;
    localparam logic [7:0] CLK_CTRL_RESET = 8'h01;
    localparam logic [7:0] PWR_MGMT_RESET = 8'h40;

    // Data space map.
    localparam logic [15:0] SRAM_TOP      = 16'h03FF;
    localparam logic [15:0] LOCK_ADDR     = 16'hFFFC;
    localparam int          SRAM_AW       = 10;
    localparam int          SRAM_DEPTH    = 1024;

    // Timing counts in clocks; EXT_BASE_MC is in machine cycles.
    localparam logic [5:0] CLK_PER_MC     = 6'h04;
    localparam logic [5:0] INT_CLKS       = 6'h08;
    localparam logic [5:0] EXT_BASE_MC    = 6'h02;
    localparam logic [5:0] ALE_CLKS       = 6'h02;
    localparam logic [5:0] ADDR_CLKS      = 6'h03;
    localparam logic [5:0] STROBE_W0      = 6'h02;
    localparam logic [5:0] SETUP_EXTRA    = 6'h01;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INT,
        ST_EXT
    } mdas_state_type;

    typedef enum logic [1:0] {
        RT_EXT,
        RT_SRAM,
        RT_LOCK,
        RT_NONE
    } mdas_route_type;

    typedef struct packed {
        logic        wr;
        logic        use_data_pointer0;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mdas_xreq_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } mdas_sfr_type;

endpackage

// >>> core/mdas_sram.sv
// On-chip data SRAM with registered read data.
`timescale 1ns/10ps
`default_nettype none
module mdas_sram
    import mdas_pkg::*;
(
    input  wire logic               clk_i,   // Core clock.
    input  wire logic               rst_i,   // Asynchronous reset.
    input  wire logic               we_i,    // Write strobe.
    input  wire logic [SRAM_AW-1:0] addr_i,  // Word address.
    input  wire logic [7:0]         wdata_i, // Write data.
    output logic      [7:0]         rdata_o  // Registered read data.
);

    logic [7:0] mem [SRAM_DEPTH];

    // Contents carry no reset so that they survive mode changes.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule
`default_nettype wire

// >>> core/mdas_core.sv
// External data move routing, cycle stretch and dual data pointers.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RL1 - With on-chip RAM on, moves to 0000h-03FFh use internal SRAM.
// RL2 - With on-chip RAM on, moves above 03FFh go to the external bus; the code does so for encoding 01 only.
// RL3 - With on-chip RAM off (reset), all moves go to the external bus.
// RL4 - Enable bits sit at bits 1:0 of register C4h, writable anytime.
// RL5 - Encoding 00 all external; 01 low 1 kB internal, rest external.
// RL6 - Encoding 11: SRAM low, lock byte at FFFCh, no external access.
// RL7 - Lock byte bits 2:0 are read-only, one per programmed lock bit.
// RL8 - Changing enable bits leaves SRAM contents untouched.
// RL9 - Internal SRAM moves always take two machine cycles.
// RL10 - Stretch field bits 2:0 at 8Eh gives external length stretch+2.
// RL11 - Stretch field resets to 1, three machine cycles.
// RL12 - Strobe is 2 clocks at stretch 0, else 4 clocks per step.
// RL13 - Nonzero stretch adds one clock of setup and of hold.
// RL14 - Stretch affects only data moves, never program fetches.
// RL15 - Two 16-bit pointers at 82h/83h and 84h/85h.
// RL16 - Bit 0 of 86h selects the pointer; other bits read 0.
// RL17 - Pointer operations act on the currently selected pointer.
// RL18 - External moves put low address/data on port 0, high on port 2.
// RL19 - Reserved encoding 10 routes everything externally.
module mdas_core
    import mdas_pkg::*;
(
    input  wire logic          clk_i,       // Core clock, 25 MHz.
    input  wire logic          rst_i,       // Asynchronous reset.
    input  wire mdas_sfr_type  sfr_i,       // Register access request.
    output logic      [7:0]    sfr_rdata_o, // Register read data.
    input  wire logic          data_pointer0_inc_i,  // Increment active pointer.
    output logic      [15:0]   data_pointer0_o,      // Active pointer value.
    input  wire logic          xreq_i,      // Move request strobe.
    input  wire mdas_xreq_type xcmd_i,      // Move request fields.
    output logic               xbusy_o,     // Move in progress.
    output logic               xdone_o,     // Move finished pulse.
    output logic      [7:0]    xrdata_o,    // Move read data.
    input  wire logic [2:0]    lock_bits_i, // Programmed lock bits.
    input  wire logic [7:0]    p0_i,        // Port 0 pin level.
    output logic      [7:0]    p0_o,        // Port 0 drive value.
    output logic               p0_oe_o,     // Port 0 drive enable.
    output logic      [7:0]    p2_o,        // Port 2 high address.
    output logic               ale_o,       // Address latch enable.
    output logic               rd_n_o,      // Read strobe, active low.
    output logic               wr_n_o       // Write strobe, active low.
);

    function automatic mdas_route_type route_of(input logic [1:0] mode,
                                                input logic [15:0] a);
        route_of = RT_EXT;
        unique case (mode)
            2'b01: begin
                if (a <= SRAM_TOP) route_of = RT_SRAM; // [RL1] [RL2] [RL5]
            end
            2'b11: begin
                if (a <= SRAM_TOP) route_of = RT_SRAM; // [RL6]
                else if (a == LOCK_ADDR) route_of = RT_LOCK; // [RL6]
                else route_of = RT_NONE; // [RL6]
            end
            default: route_of = RT_EXT; // [RL3] [RL19]
        endcase
    endfunction

    // Whole external move length in clocks.
    function automatic logic [5:0] ext_len(input logic [2:0] s);
        ext_len = 6'(({3'b000, s} + EXT_BASE_MC) * CLK_PER_MC); // [RL10]
    endfunction

    function automatic logic [5:0] strobe_w(input logic [2:0] s);
        strobe_w = (s == 3'h0) ? STROBE_W0
                               : 6'({3'b000, s} * CLK_PER_MC); // [RL12]
    endfunction

    function automatic logic [5:0] strobe_start(input logic [2:0] s);
        strobe_start = (s == 3'h0) ? ADDR_CLKS
                                   : 6'(ADDR_CLKS + SETUP_EXTRA); // [RL13]
    endfunction

    logic [7:0]     dp0_lo_reg;
    logic [7:0]     dp0_hi_reg;
    logic [7:0]     dp1_lo_reg;
    logic [7:0]     dp1_hi_reg;
    logic           sel_reg;
    logic [7:0]     clk_ctrl_reg;
    logic [7:0]     pwr_mgmt_reg;
    mdas_state_type state_reg;
    mdas_route_type route_reg;
    logic [5:0]     cnt_reg;
    logic [2:0]     stretch_reg;
    logic           wr_reg;
    logic [15:0]    addr_reg;
    logic [7:0]     wdata_reg;
    logic [7:0]     sram_rdata;
    logic [15:0]    act_ptr;
    logic [15:0]    act_ptr_next;
    logic [15:0]    req_addr;
    logic [1:0]     mode;
    mdas_route_type req_route;
    logic           accept;
    logic           sram_we;
    logic [5:0]     st_start;
    logic [5:0]     st_end;
    logic [5:0]     last_cnt;
    logic           wr_hit;

    assign mode      = {pwr_mgmt_reg[DME_HI_BIT], pwr_mgmt_reg[DME_LO_BIT]};
    assign act_ptr   = sel_reg ? {dp1_hi_reg, dp1_lo_reg}
                               : {dp0_hi_reg, dp0_lo_reg}; // [RL17]
    assign act_ptr_next = act_ptr + 16'h0001;
    assign req_addr  = xcmd_i.use_data_pointer0 ? act_ptr : xcmd_i.addr; // [RL17]
    assign req_route = route_of(mode, req_addr);
    assign accept    = xreq_i && (state_reg == ST_IDLE);
    assign st_start  = strobe_start(stretch_reg);
    assign st_end    = 6'(st_start + strobe_w(stretch_reg));
    assign last_cnt  = (state_reg == ST_EXT) ? 6'(ext_len(stretch_reg) - 6'h01)
                                             : 6'(INT_CLKS - 6'h01);
    assign wr_hit    = sfr_i.wr;

    // Only a routed SRAM write touches the array, never a mode change.
    assign sram_we = (state_reg == ST_INT) && (route_reg == RT_SRAM)
                     && wr_reg && (cnt_reg == 6'h00); // [RL8]

    mdas_sram u_sram (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (sram_we),
        .addr_i  (addr_reg[SRAM_AW-1:0]),
        .wdata_i (wdata_reg),
        .rdata_o (sram_rdata)
    );

    // Pointer registers; a register write beats a same-cycle increment.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dp0_lo_reg <= DP_RESET;
            dp0_hi_reg <= DP_RESET;
            dp1_lo_reg <= DP_RESET;
            dp1_hi_reg <= DP_RESET;
        end else if (wr_hit) begin
            if (sfr_i.addr == DP0_LOW_ADDR) dp0_lo_reg <= sfr_i.wdata; // [RL15]
            if (sfr_i.addr == DP0_HIGH_ADDR) dp0_hi_reg <= sfr_i.wdata;
            if (sfr_i.addr == DP1_LOW_ADDR) dp1_lo_reg <= sfr_i.wdata;
            if (sfr_i.addr == DP1_HIGH_ADDR) dp1_hi_reg <= sfr_i.wdata;
        end else if (data_pointer0_inc_i) begin
            if (sel_reg) begin
                {dp1_hi_reg, dp1_lo_reg} <= act_ptr_next; // [RL17]
            end else begin
                {dp0_hi_reg, dp0_lo_reg} <= act_ptr_next; // [RL17]
            end
        end
    end

    // Control registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_reg      <= PTR_SEL_RESET[PTR_SEL_BIT];
            clk_ctrl_reg <= CLK_CTRL_RESET; // [RL11]
            pwr_mgmt_reg <= PWR_MGMT_RESET; // [RL3]
        end else if (wr_hit) begin
            if (sfr_i.addr == PTR_SEL_ADDR) begin
                sel_reg <= sfr_i.wdata[PTR_SEL_BIT]; // [RL16]
            end
            if (sfr_i.addr == CLK_CTRL_ADDR) begin
                clk_ctrl_reg <= sfr_i.wdata; // [RL10]
            end
            if (sfr_i.addr == PWR_MGMT_ADDR) begin
                pwr_mgmt_reg <= sfr_i.wdata; // [RL4]
            end
        end
    end

    // Register read port, one clock after the read strobe.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_i.rd) begin
            unique case (sfr_i.addr)
                DP0_LOW_ADDR:  sfr_rdata_o <= dp0_lo_reg; // [RL15]
                DP0_HIGH_ADDR: sfr_rdata_o <= dp0_hi_reg;
                DP1_LOW_ADDR:  sfr_rdata_o <= dp1_lo_reg;
                DP1_HIGH_ADDR: sfr_rdata_o <= dp1_hi_reg;
                PTR_SEL_ADDR:  sfr_rdata_o <= {7'h00, sel_reg}; // [RL16]
                CLK_CTRL_ADDR: sfr_rdata_o <= clk_ctrl_reg;
                PWR_MGMT_ADDR: sfr_rdata_o <= pwr_mgmt_reg;
                default:       sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_pointer0_o <= 16'h0000;
        end else begin
            data_pointer0_o <= act_ptr;
        end
    end

    // Move sequencer. The stretch is latched per move so a mid-move
    // register write cannot warp the bus timing. Program fetches never
    // pass through here, so their timing ignores the stretch. [RL14]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            route_reg   <= RT_EXT;
            cnt_reg     <= 6'h00;
            stretch_reg <= CLK_CTRL_RESET[STRETCH_MSB:STRETCH_LSB];
            wr_reg      <= 1'b0;
            addr_reg    <= 16'h0000;
            wdata_reg   <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        route_reg   <= req_route;
                        wr_reg      <= xcmd_i.wr;
                        addr_reg    <= req_addr;
                        wdata_reg   <= xcmd_i.wdata;
                        stretch_reg <= clk_ctrl_reg[STRETCH_MSB:STRETCH_LSB];
                        cnt_reg     <= 6'h00;
                        state_reg   <= (req_route == RT_EXT) ? ST_EXT
                                                             : ST_INT; // [RL9]
                    end
                end
                ST_INT, ST_EXT: begin
                    if (cnt_reg == last_cnt) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= 6'(cnt_reg + 6'h01);
                    end
                end
            endcase
        end
    end

    // Move answer: done pulse, busy level and read data.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xbusy_o  <= 1'b0;
            xdone_o  <= 1'b0;
            xrdata_o <= 8'h00;
        end else begin
            xdone_o <= (state_reg != ST_IDLE) && (cnt_reg == last_cnt);
            xbusy_o <= accept || ((state_reg != ST_IDLE)
                                  && (cnt_reg != last_cnt));
            if ((state_reg == ST_INT) && !wr_reg && (cnt_reg == 6'h01)) begin
                unique case (route_reg)
                    RT_SRAM: xrdata_o <= sram_rdata; // [RL1]
                    RT_LOCK: xrdata_o <= {5'h00, lock_bits_i}; // [RL7]
                    default: xrdata_o <= 8'h00;
                endcase
            end
            // Pin data is taken in the last clock of the read strobe.
            if ((state_reg == ST_EXT) && !wr_reg && (cnt_reg == st_end)) begin
                xrdata_o <= p0_i; // [RL18]
            end
        end
    end

    // External bus pins, each one clock behind the sequencer count.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ale_o   <= 1'b0;
            rd_n_o  <= 1'b1;
            wr_n_o  <= 1'b1;
            p0_o    <= 8'h00;
            p0_oe_o <= 1'b0;
            p2_o    <= 8'h00;
        end else if (state_reg == ST_EXT) begin
            ale_o  <= cnt_reg < ALE_CLKS;
            rd_n_o <= !(!wr_reg && (cnt_reg >= st_start)
                        && (cnt_reg < st_end)); // [RL12] [RL13]
            wr_n_o <= !(wr_reg && (cnt_reg >= st_start)
                        && (cnt_reg < st_end)); // [RL12] [RL13]
            p2_o   <= addr_reg[15:8]; // [RL18]
            if (cnt_reg < ADDR_CLKS) begin
                p0_o    <= addr_reg[7:0]; // [RL18]
                p0_oe_o <= 1'b1;
            end else begin
                p0_o    <= wdata_reg;
                p0_oe_o <= wr_reg;
            end
        end else begin
            ale_o   <= 1'b0;
            rd_n_o  <= 1'b1;
            wr_n_o  <= 1'b1;
            p0_oe_o <= 1'b0;
        end
    end

    // Checks.
    logic [5:0] strobe_cnt;
    logic       strobe_low;

    assign strobe_low = !rd_n_o || !wr_n_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_cnt <= 6'h00;
        end else if (strobe_low) begin
            strobe_cnt <= 6'(strobe_cnt + 6'h01);
        end else begin
            strobe_cnt <= 6'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_SRAM_NO_BUS: assert property ( // [RL1]
        (state_reg == ST_INT) |=> (rd_n_o && wr_n_o && !ale_o))
        else $error("internal move disturbed the external bus");

    AST_HIGH_EXTERNAL: assert property ( // [RL2]
        (accept && (mode == 2'b01) && (req_addr > SRAM_TOP))
        |=> (state_reg == ST_EXT) ##2 ale_o)
        else $error("high address not sent to external bus");

    AST_OFF_EXTERNAL: assert property ( // [RL3]
        (accept && !pwr_mgmt_reg[DME_LO_BIT]) |=> (state_reg == ST_EXT))
        else $error("move not external with on-chip RAM off");

    AST_MODE3_NO_EXT: assert property ( // [RL6]
        (accept && (mode == 2'b11))
        |=> (rd_n_o && wr_n_o && !ale_o) [*8])
        else $error("external access in lock status mode");

    AST_INT_TWO_MC: assert property ( // [RL9]
        (accept && (req_route != RT_EXT)) |-> ##9 xdone_o)
        else $error("internal move not two machine cycles");

    AST_STROBE_WIDTH: assert property ( // [RL12]
        (strobe_low ##1 !strobe_low) |->
        ($past(strobe_cnt) + 6'h01 == strobe_w(stretch_reg)))
        else $error("strobe width wrong for stretch value");

    // The strobe must not start before the latch has closed and the
    // address has had its one clock, or two with any stretch.
    AST_SETUP: assert property ( // [RL13]
        $rose(ale_o) |-> (if (stretch_reg == 3'h0)
            (##2 (!ale_o && !strobe_low) ##1 strobe_low)
        else
            (##2 (!ale_o && !strobe_low) ##1 !strobe_low ##1 strobe_low)))
        else $error("address setup wrong for stretch value");

    AST_LOCK_READ: assert property ( // [RL7]
        (state_reg == ST_INT && route_reg == RT_LOCK && !wr_reg
         && cnt_reg == 6'h01) |=> (xrdata_o == {5'h00, $past(lock_bits_i)}))
        else $error("lock status byte wrong");

    AST_SEL_READ: assert property ( // [RL16]
        (sfr_i.rd && sfr_i.addr == PTR_SEL_ADDR)
        |=> (sfr_rdata_o[7:1] == 7'h00))
        else $error("pointer select upper bits not zero");

    AST_PTR_INC: assert property ( // [RL17]
        (data_pointer0_inc_i && !wr_hit) |=> (act_ptr == $past(act_ptr_next)))
        else $error("active pointer not incremented");

    COV_EXT_READ: cover property (
        (state_reg == ST_EXT) && !wr_reg ##1 xdone_o);
    COV_SRAM_WRITE: cover property (sram_we);
    COV_LOCK_READ: cover property (
        (state_reg == ST_INT) && (route_reg == RT_LOCK));
    COV_MAX_STRETCH: cover property (
        strobe_low && (stretch_reg == 3'h7));

endmodule
`default_nettype wire

// >>> verification/mdas_ext_mem_model.sv
// Behavioural external data memory on the multiplexed port 0 and port 2 bus.
`timescale 1ns/10ps
`default_nettype none
module mdas_ext_mem_model (
    input  wire logic       clk_i,    // Core clock.
    input  wire logic [7:0] p0_pin_i, // Resolved port 0 level.
    input  wire logic [7:0] p2_i,     // High address byte.
    input  wire logic       ale_i,    // Address latch enable.
    input  wire logic       rd_n_i,   // Read strobe, active low.
    input  wire logic       wr_n_i,   // Write strobe, active low.
    output logic      [7:0] p0_o,     // Model drive onto port 0.
    output int              acc_o,    // Bus cycles seen.
    output int              width_o,  // Last strobe width in clocks.
    output int              gap_o     // Clocks from latch end to strobe.
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat_reg;
    logic [7:0]  last_reg;
    logic        ale_reg;
    logic        armed_reg;
    logic [15:0] addr;
    assign addr = {p2_i, lat_reg};
    // A released bus shows the inverse of the last byte, so a design that
    // samples outside the strobe cannot pass by luck.
    assign p0_o = rd_n_i ? ~last_reg : mem[addr];
    always @(posedge clk_i) begin
        ale_reg <= ale_i;
        if (ale_i) lat_reg <= p0_pin_i;
        if (ale_i && !ale_reg) acc_o <= acc_o + 1;
        if (ale_i) width_o <= 0;
        else if (!rd_n_i || !wr_n_i) width_o <= width_o + 1;
        if (ale_i) begin
            gap_o     <= 0;
            armed_reg <= 1'b1;
        end else if (armed_reg && rd_n_i && wr_n_i) gap_o <= gap_o + 1;
        else armed_reg <= 1'b0;
        if (!rd_n_i) last_reg <= mem[addr];
        // Write data is taken on clock edges inside the strobe, never on
        // the strobe edge that shares a time step with the clock.
        if (!wr_n_i) mem[addr] <= p0_pin_i;
    end
endmodule
`default_nettype wire

// >>> verification/mdas_testbench.sv
// Self-checking bench for the external data move access unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mdas_pkg::*;
    localparam int CYC_I = 8;
    localparam int CYC_E = 12;
    localparam logic [7:0] RST_ADDR [8] = '{8'h82, 8'h83, 8'h84, 8'h85,
        8'h86, 8'h8E, 8'hC4, 8'h90};
    localparam logic [7:0] RST_VAL [8] = '{DP_RESET, DP_RESET, DP_RESET,
        DP_RESET, PTR_SEL_RESET, CLK_CTRL_RESET, PWR_MGMT_RESET, 8'h00};
    logic          clk_i, rst_i, data_pointer0_inc_i, xreq_i, xbusy_o, xdone_o;
    logic          p0_oe_o, ale_o, rd_n_o, wr_n_o;
    mdas_sfr_type  sfr_i;
    mdas_xreq_type xcmd_i;
    logic [7:0]    sfr_rdata_o, xrdata_o, p0_i, p0_o, p2_o, mdl_p0;
    logic [15:0]   data_pointer0_o;
    logic [2:0]    lock_bits_i;
    int            acc, width, gap, fails, comparisons;
    assign p0_i = p0_oe_o ? p0_o : mdl_p0;
    mdas_core mdas_core_inst (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
        .sfr_rdata_o(sfr_rdata_o), .data_pointer0_inc_i(data_pointer0_inc_i),
        .data_pointer0_o(data_pointer0_o), .xreq_i(xreq_i), .xcmd_i(xcmd_i),
        .xbusy_o(xbusy_o), .xdone_o(xdone_o), .xrdata_o(xrdata_o),
        .lock_bits_i(lock_bits_i), .p0_i(p0_i), .p0_o(p0_o),
        .p0_oe_o(p0_oe_o), .p2_o(p2_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
        .wr_n_o(wr_n_o));
    mdas_ext_mem_model mdas_ext_mem_model_inst (.clk_i(clk_i),
        .p0_pin_i(p0_i), .p2_i(p2_o), .ale_i(ale_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .p0_o(mdl_p0), .acc_o(acc), .width_o(width),
        .gap_o(gap));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [15:0] exp,
             input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Each register task keeps one idle cycle at its end, so a strobe is
    // never set and cleared in the same time step.
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_i = '{1'b1, 1'b0, a, d};
        @(negedge clk_i) sfr_i = '0;
        @(negedge clk_i);
    endtask
    task sfr_rd(input logic [7:0] a, output logic [7:0] d);
        sfr_i = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i) d = sfr_rdata_o;
        sfr_i = '0;
        @(negedge clk_i);
    endtask
    task inc_ptr;
        data_pointer0_inc_i = 1'b1;
        @(negedge clk_i) data_pointer0_inc_i = 1'b0;
        @(negedge clk_i);
    endtask
    task move_chk(input logic wr, input logic usep, input logic [15:0] a,
                  input logic [7:0] wd, input int nexp, input int aexp,
                  input logic [7:0] rexp);
        int a0;
        int n;
        a0 = acc;
        xreq_i = 1'b1;
        xcmd_i = '{wr, usep, a, wd};
        @(negedge clk_i) xreq_i = 1'b0;
        n = 0;
        while (xdone_o !== 1'b1) begin
            chk("busy in move", 16'h0001, xbusy_o);
            @(negedge clk_i);
            n++;
            if (n > 60) begin
                fails++;
                $display("[ERR] move done expected pulse seen none");
                tally_and_finish;
            end
        end
        chk("busy at done", 16'h0000, xbusy_o);
        chk("move cycles", nexp, n);
        chk("bus cycles", aexp, acc - a0);
        if (!wr) chk("move read data", rexp, xrdata_o);
    endtask
    task t_reset;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            sfr_rd(RST_ADDR[i], d);
            chk("reset value", RST_VAL[i], d);
        end
        chk("pointer at reset", 16'h0000, data_pointer0_o);
        chk("idle strobes", 16'h0003, {rd_n_o, wr_n_o});
        move_chk(1, 0, 16'h0020, 8'h5A, CYC_E, 1, 8'h00);
        $display("test reset done");
    endtask
    task t_stretch;
        logic [7:0] d;
        for (int s = 0; s < 8; s++) begin
            sfr_wr(CLK_CTRL_ADDR, 8'(s));
            sfr_rd(CLK_CTRL_ADDR, d);
            chk("stretch field", 16'(s), d);
            move_chk(1, 0, 16'h1200 + 16'(s), 8'hA0 + 8'(s),
                     (s + 2) * 4, 1, 8'h00);
            chk("strobe width", s == 0 ? 2 : 4 * s, width);
            chk("setup gap", s == 0 ? 1 : 2, gap);
            move_chk(0, 0, 16'h1200 + 16'(s), 8'h00,
                     (s + 2) * 4, 1, 8'hA0 + 8'(s));
        end
        $display("test stretch done");
    endtask
    task t_route;
        logic [7:0] d;
        sfr_wr(CLK_CTRL_ADDR, 8'h01);
        move_chk(1, 0, 16'h0010, 8'hAA, CYC_E, 1, 8'h00);
        move_chk(0, 0, 16'h0010, 8'h00, CYC_E, 1, 8'hAA);
        sfr_wr(PWR_MGMT_ADDR, 8'h41);
        sfr_rd(PWR_MGMT_ADDR, d);
        chk("routing bits", 16'h0041, d);
        move_chk(1, 0, 16'h0010, 8'h55, CYC_I, 0, 8'h00);
        move_chk(1, 0, 16'h03FF, 8'h3C, CYC_I, 0, 8'h00);
        move_chk(0, 0, 16'h0010, 8'h00, CYC_I, 0, 8'h55);
        move_chk(1, 0, 16'h0400, 8'hC3, CYC_E, 1, 8'h00);
        move_chk(0, 0, 16'h0400, 8'h00, CYC_E, 1, 8'hC3);
        sfr_wr(PWR_MGMT_ADDR, 8'h42);
        move_chk(0, 0, 16'h0010, 8'h00, CYC_E, 1, 8'hAA);
        sfr_wr(PWR_MGMT_ADDR, 8'h43);
        move_chk(0, 0, 16'h0010, 8'h00, CYC_I, 0, 8'h55);
        move_chk(0, 0, 16'hFFFC, 8'h00, CYC_I, 0, 8'h05);
        move_chk(1, 0, 16'hFFFC, 8'hFF, CYC_I, 0, 8'h00);
        lock_bits_i = 3'b010;
        move_chk(0, 0, 16'hFFFC, 8'h00, CYC_I, 0, 8'h02);
        move_chk(1, 0, 16'h0400, 8'h11, CYC_I, 0, 8'h00);
        move_chk(0, 0, 16'h8000, 8'h00, CYC_I, 0, 8'h00);
        move_chk(0, 0, 16'hFFFD, 8'h00, CYC_I, 0, 8'h00);
        sfr_wr(PWR_MGMT_ADDR, 8'h41);
        move_chk(0, 0, 16'h03FF, 8'h00, CYC_I, 0, 8'h3C);
        move_chk(0, 0, 16'h0400, 8'h00, CYC_E, 1, 8'hC3);
        sfr_wr(PWR_MGMT_ADDR, 8'h40);
        $display("test route done");
    endtask
    task t_pointers;
        logic [7:0] d;
        sfr_wr(DP0_LOW_ADDR, 8'h34);
        sfr_wr(DP0_HIGH_ADDR, 8'h12);
        sfr_wr(DP1_LOW_ADDR, 8'h78);
        sfr_wr(DP1_HIGH_ADDR, 8'h56);
        chk("pointer 0", 16'h1234, data_pointer0_o);
        sfr_wr(PTR_SEL_ADDR, 8'hFF);
        sfr_rd(PTR_SEL_ADDR, d);
        chk("select register", 16'h0001, d);
        chk("pointer 1", 16'h5678, data_pointer0_o);
        inc_ptr;
        chk("increment", 16'h5679, data_pointer0_o);
        sfr_wr(PTR_SEL_ADDR, 8'hFE);
        chk("pointer 0 again", 16'h1234, data_pointer0_o);
        sfr_rd(DP1_LOW_ADDR, d);
        chk("pointer 1 low", 16'h0079, d);
        sfr_wr(DP0_LOW_ADDR, 8'hFF);
        sfr_wr(DP0_HIGH_ADDR, 8'hFF);
        inc_ptr;
        chk("pointer wrap", 16'h0000, data_pointer0_o);
        sfr_wr(DP0_HIGH_ADDR, 8'h12);
        move_chk(0, 1, 16'hFFFF, 8'h00, CYC_E, 1, 8'hA0);
        $display("test pointers done");
    endtask
    initial begin
        rst_i = 1'b1;
        sfr_i = '0;
        xreq_i = 1'b0;
        xcmd_i = '0;
        data_pointer0_inc_i = 1'b0;
        lock_bits_i = 3'b101;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset;
        t_stretch;
        t_route;
        t_pointers;
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
